// [tb/tb_clock_ctrl.sv]
// self-checking bench for the clock control block, driven over apb
`timescale 1ns/10ps
module tb_clock_ctrl;
  localparam int SLOW_HALF = 16;
  localparam int MAIN_HALF = 2;
  localparam int PLL_HALF = 3;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic slow_clk_in, main_clk_in, pll_clk_in, osc_on, osc_bypass, pll_ref_out, pll_on;
  logic usb_clk_out, mck_out, irq;
  logic [10:0] pll_factor_out;
  logic [1:0] pll_range_out;
  logic [2:0] pck_out;
  logic [5:0] clk_vec;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int el, per;
  ////////////////////////////////////////////////////////////////////////////////////////////////
  clock_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slow_clk_in(slow_clk_in), .main_clk_in(main_clk_in),
    .pll_clk_in(pll_clk_in), .osc_on(osc_on), .osc_bypass(osc_bypass),
    .pll_ref_out(pll_ref_out), .pll_on(pll_on), .pll_factor_out(pll_factor_out),
    .pll_range_out(pll_range_out), .usb_clk_out(usb_clk_out), .mck_out(mck_out),
    .pck_out(pck_out), .irq(irq));
  assign clk_vec = {pll_ref_out, usb_clk_out, pck_out, mck_out};
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // source clocks derived from pclk so every expected ratio is exact
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % SLOW_HALF == 0) slow_clk_in <= ~slow_clk_in;
    if (cyc % MAIN_HALF == 0) main_clk_in <= ~main_clk_in;
    if (cyc % PLL_HALF == 0) pll_clk_in <= ~pll_clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////////////////////
  task results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task give_up();
    n_errors++;
    $display("timeout while waiting at cycle %0d", cyc);
    results();
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one transfer; request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) give_up();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // polls a register bit; el gets the cycles spent until it reads v
  task wait_bit(input logic [7:0] a, input int b, input logic v, input int maxc);
    int s;
    s = cyc;
    el = -1;
    while (cyc - s < maxc && el < 0) begin
      apb(1'b0, a, 32'h0000_0000);
      if (rd[b] === v) el = cyc - s;
    end
    if (el < 0) give_up();
  endtask
  // second full period of an output clock; a stuck output gives 0
  task period(input int idx, input int bound, input logic must);
    int n, last, edges;
    logic pv;
    edges = 0;
    last = 0;
    per = 0;
    pv = clk_vec[idx];
    for (n = 0; n < bound && edges < 3; n++) begin
      @(posedge pclk);
      #1;
      if (clk_vec[idx] === 1'b1 && pv === 1'b0) begin
        edges++;
        if (edges == 3) per = cyc - last;
        last = cyc;
      end
      pv = clk_vec[idx];
    end
    if (must && edges < 3) give_up();
  endtask
  function automatic logic [31:0] pll_word(input int dv, input int st, input int f, input int u);
    return {2'h0, 2'(u), 1'b0, 11'(f), 2'h2, 6'(st), 8'(dv)};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {slow_clk_in, main_clk_in, pll_clk_in} = 3'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, read-only places and an unmapped address
    apb(1'b0, clock_ctrl_pkg::OFF_CLOCK_STATUS, 32'h0);
    check("status reset", rd, 32'h0000_0008);
    apb(1'b0, clock_ctrl_pkg::OFF_PLL_CONFIG, 32'h0);
    check("pll config reset", rd, clock_ctrl_pkg::PLL_CONFIG_RESET);
    apb(1'b0, clock_ctrl_pkg::OFF_MAIN_FREQ_MEASURE, 32'h0);
    check("measure invalid while off", rd, 32'h0000_0000);
    apb(1'b1, clock_ctrl_pkg::OFF_CLOCK_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, clock_ctrl_pkg::OFF_CLOCK_STATUS, 32'h0);
    check("status ignores writes", rd, 32'h0000_0008);
    apb(1'b0, 8'h80, 32'h0);
    check("unmapped read", {rd[30:0], err}, 32'h0000_0001);
    $display("test reset done");
    // interrupt enable, disable and mask share the status layout
    apb(1'b0, clock_ctrl_pkg::OFF_IRQ_MASK, 32'h0);
    check("mask all disabled", rd, clock_ctrl_pkg::IRQ_BITS);
    apb(1'b1, clock_ctrl_pkg::OFF_IRQ_ENABLE, 32'h0000_0008);
    repeat (2) @(posedge pclk);
    check("irq from master ready", {31'h0, irq}, 32'h1);
    apb(1'b1, clock_ctrl_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
    apb(1'b0, clock_ctrl_pkg::OFF_IRQ_MASK, 32'h0);
    check("enable zero keeps", rd, clock_ctrl_pkg::IRQ_BITS & ~32'h8);
    apb(1'b1, clock_ctrl_pkg::OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
    apb(1'b1, clock_ctrl_pkg::OFF_IRQ_DISABLE, 32'h0000_0000);
    apb(1'b0, clock_ctrl_pkg::OFF_IRQ_MASK, 32'h0);
    check("disable zero keeps", rd, 32'h0000_0000);
    apb(1'b1, clock_ctrl_pkg::OFF_IRQ_DISABLE, 32'hFFFF_FFFB);
    repeat (2) @(posedge pclk);
    check("irq off when masked", {31'h0, irq}, 32'h0);
    apb(1'b0, clock_ctrl_pkg::OFF_IRQ_MASK, 32'h0);
    check("only lock enabled", rd, clock_ctrl_pkg::IRQ_BITS & ~32'h4);
    $display("test interrupts done");
    // oscillator start-up of 2 units, then one frequency measurement
    apb(1'b1, clock_ctrl_pkg::OFF_OSC_CTRL, 32'h0000_0201);
    repeat (2) @(posedge pclk);
    check("osc pins", {30'h0, osc_bypass, osc_on}, 32'h1);
    wait_bit(clock_ctrl_pkg::OFF_CLOCK_STATUS, clock_ctrl_pkg::BIT_OSC, 1'b1, 2000);
    check("start-up not early", 32'(el >= 15 * 2 * SLOW_HALF), 32'h1);
    check("start-up not late", 32'(el <= 17 * 2 * SLOW_HALF + 20), 32'h1);
    wait_bit(clock_ctrl_pkg::OFF_MAIN_FREQ_MEASURE, clock_ctrl_pkg::BIT_MEAS_VALID, 1'b1, 1500);
    check("main cycle count", {16'h0, rd[15:0]}, 32'(16 * SLOW_HALF / MAIN_HALF));
    $display("test oscillator done");
    // pll: settle of 3 slow cycles, lock interrupt, then switched off
    apb(1'b1, clock_ctrl_pkg::OFF_PLL_CONFIG, pll_word(1, 3, 5, 0));
    repeat (2) @(posedge pclk);
    check("pll factor pins", {18'h0, pll_on, pll_range_out, pll_factor_out}, 32'h0000_3005);
    wait_bit(clock_ctrl_pkg::OFF_CLOCK_STATUS, clock_ctrl_pkg::BIT_LOCK, 1'b1, 400);
    check("lock not early", 32'(el >= 2 * 2 * SLOW_HALF), 32'h1);
    check("lock not late", 32'(el <= 3 * 2 * SLOW_HALF + 20), 32'h1);
    repeat (2) @(posedge pclk);
    check("irq on lock", {31'h0, irq}, 32'h1);
    apb(1'b0, clock_ctrl_pkg::OFF_PLL_CONFIG, 32'h0);
    check("pll readback", rd, pll_word(1, 3, 5, 0));
    apb(1'b1, clock_ctrl_pkg::OFF_PLL_CONFIG, pll_word(1, 0, 0, 0));
    repeat (2) @(posedge pclk);
    check("pll off", {31'h0, pll_on}, 32'h0);
    wait_bit(clock_ctrl_pkg::OFF_CLOCK_STATUS, clock_ctrl_pkg::BIT_LOCK, 1'b0, 40);
    repeat (2) @(posedge pclk);
    check("irq drops", {31'h0, irq}, 32'h0);
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, clock_ctrl_pkg::OFF_PLL_CONFIG, pll_word(d, 0, 5, 0));
      period(5, 400, d != 0);
      check("reference divide", 32'(per), 32'(d * 2 * MAIN_HALF));
    end
    for (int u = 0; u < 4; u++) begin
      apb(1'b1, clock_ctrl_pkg::OFF_PLL_CONFIG, pll_word(1, 0, 5, u));
      period(4, 400, u != 3);
      check("usb divide", 32'(per), u == 3 ? 32'h0 : 32'((2 * PLL_HALF) << u));
    end
    $display("test pll done");
    // master clock: every prescaler on main, slow source, both reserved codes
    for (int p = 0; p < 7; p++) begin
      apb(1'b1, clock_ctrl_pkg::OFF_MASTER_CLOCK_CONFIG, 32'((p << 2) | 1));
      wait_bit(clock_ctrl_pkg::OFF_CLOCK_STATUS, clock_ctrl_pkg::BIT_MCK, 1'b1, 2000);
      period(0, 1200, 1'b1);
      check("master prescale", 32'(per), 32'((2 * MAIN_HALF) << p));
    end
    apb(1'b1, clock_ctrl_pkg::OFF_MASTER_CLOCK_CONFIG, 32'h0000_0000);
    wait_bit(clock_ctrl_pkg::OFF_CLOCK_STATUS, clock_ctrl_pkg::BIT_MCK, 1'b1, 2000);
    period(0, 400, 1'b1);
    check("master on slow", 32'(per), 32'(2 * SLOW_HALF));
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, clock_ctrl_pkg::OFF_MASTER_CLOCK_CONFIG, k == 0 ? 32'h0000_0002 : 32'h0000_001D);
      wait_bit(clock_ctrl_pkg::OFF_CLOCK_STATUS, clock_ctrl_pkg::BIT_MCK, 1'b0, 40);
      period(0, 200, 1'b0);
      check("reserved gives no clock", 32'(per), 32'h0);
    end
    // programmable clocks, each its own register, on the pll source
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'(clock_ctrl_pkg::OFF_PROG_CLOCK0 + 4 * i), 32'((i << 2) | 3));
      wait_bit(clock_ctrl_pkg::OFF_CLOCK_STATUS, clock_ctrl_pkg::BIT_PCK0 + i, 1'b1, 2000);
      period(1 + i, 400, 1'b1);
      check("prog clock period", 32'(per), 32'((2 * PLL_HALF) << i));
      apb(1'b0, 8'(clock_ctrl_pkg::OFF_PROG_CLOCK0 + 4 * i), 32'h0);
      check("prog clock readback", rd, 32'((i << 2) | 3));
    end
    $display("test clock select done");
    results();
  end
endmodule

// [verilog/clock_ctrl.sv]
// clock generator and master clock control block with apb register access
`timescale 1ns/10ps
module clock_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_clk_in,
  input wire logic main_clk_in,
  input wire logic pll_clk_in,
  output logic osc_on,
  output logic osc_bypass,
  output logic pll_ref_out,
  output logic pll_on,
  output logic [10:0] pll_factor_out,
  output logic [1:0] pll_range_out,
  output logic usb_clk_out,
  output logic mck_out,
  output logic [2:0] pck_out,
  output logic irq
);

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_SYNC = 2'b01,
    MS_COUNT = 2'b10,
    MS_DONE = 2'b11
  } meas_state_t;

  logic [31:0] osc_ctrl;
  clock_ctrl_pkg::pll_cfg_t pll_cfg;
  clock_ctrl_pkg::clk_cfg_t clk_cfg [clock_ctrl_pkg::NUM_CLK];
  logic [31:0] irq_en;
  logic [2:0] slow_sync, main_sync, pll_sync;
  logic slow_rise, main_rise, pll_rise;
  logic osc_stable;
  logic [10:0] osc_cnt;
  logic osc_on_q;
  logic lock, lock_busy;
  logic [5:0] lock_cnt;
  meas_state_t meas_state;
  logic [4:0] meas_slow;
  logic [15:0] meas_cnt, main_cycle_count;
  logic measure_valid_flag;
  logic [7:0] ref_cnt;
  logic [1:0] usb_cnt;
  logic [clock_ctrl_pkg::NUM_CLK-1:0] clk_ok, clk_q, clk_wr;
  logic [31:0] status_word, mask_word, read_word;
  logic wr_acc, rd_setup, addr_ok, pll_wr;

  //////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, read data captured in the setup cycle
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pll_wr = wr_acc && paddr == clock_ctrl_pkg::OFF_PLL_CONFIG;

  // register decode for reads, and whether the address is mapped at all
  always_comb begin
    read_word = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      clock_ctrl_pkg::OFF_OSC_CTRL: read_word = osc_ctrl;
      clock_ctrl_pkg::OFF_MAIN_FREQ_MEASURE: read_word = {15'h0000, measure_valid_flag,
                                                          main_cycle_count};
      clock_ctrl_pkg::OFF_PLL_CONFIG: read_word = pll_cfg;
      clock_ctrl_pkg::OFF_MASTER_CLOCK_CONFIG: read_word = {27'h0, clk_cfg[0]};
      clock_ctrl_pkg::OFF_PROG_CLOCK0: read_word = {27'h0, clk_cfg[1]};
      clock_ctrl_pkg::OFF_PROG_CLOCK1: read_word = {27'h0, clk_cfg[2]};
      clock_ctrl_pkg::OFF_PROG_CLOCK2: read_word = {27'h0, clk_cfg[3]};
      clock_ctrl_pkg::OFF_IRQ_ENABLE: read_word = 32'h0000_0000;
      clock_ctrl_pkg::OFF_IRQ_DISABLE: read_word = 32'h0000_0000;
      clock_ctrl_pkg::OFF_CLOCK_STATUS: read_word = status_word;
      clock_ctrl_pkg::OFF_IRQ_MASK: read_word = mask_word;
      default: addr_ok = 1'b0;
    endcase
  end

  // read data and error flag come from flops, held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= rd_setup ? read_word : 32'h0000_0000;
      pslverr <= !addr_ok;
    end
  end

  // status and mask words share one layout
  assign status_word = {21'h0, clk_ok[3:1], 4'h0, clk_ok[0], lock, 1'b0, osc_stable};
  assign mask_word = ~irq_en & clock_ctrl_pkg::IRQ_BITS;

  //////////////////////////////////////////////////////////////////////////
  // interrupt enables: set and clear registers never touch unwritten bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= 32'h0000_0000;
    end else if (wr_acc && paddr == clock_ctrl_pkg::OFF_IRQ_ENABLE) begin
      irq_en <= irq_en | (pwdata & clock_ctrl_pkg::IRQ_BITS);
    end else if (wr_acc && paddr == clock_ctrl_pkg::OFF_IRQ_DISABLE) begin
      irq_en <= irq_en & ~pwdata;
    end
  end

  // level interrupt: status flags are live levels, so nothing is sticky
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_word & irq_en);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration registers; reserved bits are dropped on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_ctrl <= 32'h0000_0000;
      pll_cfg <= clock_ctrl_pkg::PLL_CONFIG_RESET;
    end else if (wr_acc) begin
      if (paddr == clock_ctrl_pkg::OFF_OSC_CTRL) begin
        osc_ctrl <= pwdata & 32'h0000_FF03;
      end
      if (pll_wr) begin
        pll_cfg <= pwdata & 32'h37FF_FFFF;
      end
    end
  end

  // analog controls; range is passed as written, software keeps it legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_on <= 1'b0;
      osc_bypass <= 1'b0;
      pll_on <= 1'b0;
      pll_factor_out <= 11'h000;
      pll_range_out <= 2'h0;
    end else begin
      osc_on <= osc_ctrl[clock_ctrl_pkg::BIT_OSC_ON];
      osc_bypass <= osc_ctrl[clock_ctrl_pkg::BIT_OSC_SKIP];
      pll_on <= pll_cfg.pll_factor != 11'h000 && pll_cfg.in_divide != 8'h00;
      pll_factor_out <= pll_cfg.pll_factor;
      pll_range_out <= pll_cfg.freq_range;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // synchronisers and edge detect; the edge logic compares stage two with stage three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_sync <= 3'h0;
      main_sync <= 3'h0;
      pll_sync <= 3'h0;
    end else begin
      slow_sync <= {slow_sync[1:0], slow_clk_in};
      main_sync <= {main_sync[1:0], main_clk_in};
      pll_sync <= {pll_sync[1:0], pll_clk_in};
    end
  end

  assign slow_rise = slow_sync[1] && !slow_sync[2];
  assign main_rise = main_sync[1] && !main_sync[2];
  assign pll_rise = pll_sync[1] && !pll_sync[2];

  //////////////////////////////////////////////////////////////////////////
  // oscillator start-up: eight slow cycles per unit of the time field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_on_q <= 1'b0;
      osc_cnt <= 11'h000;
      osc_stable <= 1'b0;
    end else begin
      osc_on_q <= osc_ctrl[clock_ctrl_pkg::BIT_OSC_ON];
      if (osc_ctrl[clock_ctrl_pkg::BIT_OSC_SKIP]) begin
        osc_stable <= 1'b1;
      end else if (!osc_ctrl[clock_ctrl_pkg::BIT_OSC_ON]) begin
        osc_stable <= 1'b0;
      end else if (!osc_on_q) begin
        osc_cnt <= {osc_ctrl[15:8], 3'h0};
        osc_stable <= 1'b0;
      end else if (osc_cnt == 11'h000) begin
        osc_stable <= 1'b1;
      end else if (slow_rise) begin
        osc_cnt <= osc_cnt - 11'h001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pll lock timer: every write restarts it, whatever changed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock <= 1'b0;
      lock_busy <= 1'b0;
      lock_cnt <= 6'h00;
    end else if (pll_wr) begin
      lock <= 1'b0;
      lock_busy <= 1'b1;
      lock_cnt <= pwdata[13:8];
    end else if (!pll_on) begin
      lock <= 1'b0;
    end else if (lock_busy && lock_cnt == 6'h00) begin
      lock <= 1'b1;
      lock_busy <= 1'b0;
    end else if (lock_busy && slow_rise) begin
      lock_cnt <= lock_cnt - 6'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pll input divider on the main clock; odd ratios above one give uneven duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt <= 8'h00;
      pll_ref_out <= 1'b0;
    end else if (pll_cfg.in_divide == 8'h00) begin
      ref_cnt <= 8'h00;
      pll_ref_out <= 1'b0;
    end else if (pll_cfg.in_divide == 8'h01) begin
      pll_ref_out <= main_sync[1];
    end else if (main_rise) begin
      ref_cnt <= (ref_cnt >= pll_cfg.in_divide - 8'h01) ? 8'h00 : ref_cnt + 8'h01;
      pll_ref_out <= ref_cnt < {1'b0, pll_cfg.in_divide[7:1]};
    end
  end

  // usb clock divider on the pll clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_cnt <= 2'h0;
      usb_clk_out <= 1'b0;
    end else begin
      if (pll_rise) begin
        usb_cnt <= usb_cnt + 2'h1;
      end
      case (pll_cfg.usb_clock_divide)
        2'h0: usb_clk_out <= pll_sync[1];
        2'h1: usb_clk_out <= usb_cnt[0];
        2'h2: usb_clk_out <= usb_cnt[1];
        default: usb_clk_out <= 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // main clock measurement over sixteen slow clock periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_state <= MS_IDLE;
      meas_slow <= 5'h00;
      meas_cnt <= 16'h0000;
      main_cycle_count <= 16'h0000;
      measure_valid_flag <= 1'b0;
    end else if (!osc_ctrl[clock_ctrl_pkg::BIT_OSC_ON]
                 && !osc_ctrl[clock_ctrl_pkg::BIT_OSC_SKIP]) begin
      meas_state <= MS_IDLE;
      measure_valid_flag <= 1'b0;
    end else begin
      case (meas_state)
        MS_IDLE: begin
          meas_state <= MS_SYNC;
        end
        MS_SYNC: begin
          if (slow_rise) begin
            meas_state <= MS_COUNT;
            meas_slow <= 5'h00;
            meas_cnt <= 16'h0000;
          end
        end
        MS_COUNT: begin
          if (main_rise && meas_cnt != 16'hFFFF) begin
            meas_cnt <= meas_cnt + 16'h0001;
          end
          if (slow_rise) begin
            meas_slow <= meas_slow + 5'h01;
            if (meas_slow + 5'h01 == clock_ctrl_pkg::MEAS_SLOW_PERIODS) begin
              meas_state <= MS_DONE;
            end
          end
        end
        MS_DONE: begin
          main_cycle_count <= meas_cnt;
          measure_valid_flag <= 1'b1;
        end
        default: meas_state <= MS_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // clock config registers: channel 0 is the master clock, 1..3 programmable
  assign clk_wr[0] = wr_acc && paddr == clock_ctrl_pkg::OFF_MASTER_CLOCK_CONFIG;
  assign clk_wr[1] = wr_acc && paddr == clock_ctrl_pkg::OFF_PROG_CLOCK0;
  assign clk_wr[2] = wr_acc && paddr == clock_ctrl_pkg::OFF_PROG_CLOCK1;
  assign clk_wr[3] = wr_acc && paddr == clock_ctrl_pkg::OFF_PROG_CLOCK2;
  assign mck_out = clk_q[0];
  assign pck_out = clk_q[3:1];

  // each channel: source mux, power-of-two prescaler, ready after settling
  for (genvar ch = 0; ch < clock_ctrl_pkg::NUM_CLK; ch++) begin : g_clk
    logic src_lvl, src_rise;
    logic [5:0] div_cnt;
    logic [1:0] settle;
    clock_ctrl_pkg::clk_cfg_t cfg;
    logic q, ok;

    // per-channel flops feed the shared vectors, so every bit keeps a single driver
    assign clk_cfg[ch] = cfg;
    assign clk_q[ch] = q;
    assign clk_ok[ch] = ok;

    always_comb begin
      case (clk_cfg[ch].source_sel)
        clock_ctrl_pkg::SRC_SLOW: begin
          src_lvl = slow_sync[1];
          src_rise = slow_rise;
        end
        clock_ctrl_pkg::SRC_MAIN: begin
          src_lvl = main_sync[1];
          src_rise = main_rise;
        end
        clock_ctrl_pkg::SRC_PLL: begin
          src_lvl = pll_sync[1];
          src_rise = pll_rise;
        end
        default: begin
          src_lvl = 1'b0;
          src_rise = 1'b0;
        end
      endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg <= clock_ctrl_pkg::CLK_CONFIG_RESET;
      end else if (clk_wr[ch]) begin
        cfg <= pwdata[4:0];
      end
    end

    // div_cnt bit n-1 toggles at 1/2^n of the source
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        div_cnt <= 6'h00;
        q <= 1'b0;
      end else begin
        if (src_rise) begin
          div_cnt <= div_cnt + 6'h01;
        end
        if (clk_cfg[ch].clock_divide_sel == 3'h0) begin
          q <= src_lvl;
        end else if (clk_cfg[ch].clock_divide_sel == clock_ctrl_pkg::CLOCK_DIVIDE_SEL_NONE) begin
          q <= 1'b0;
        end else begin
          q <= div_cnt[clk_cfg[ch].clock_divide_sel - 3'h1];
        end
      end
    end

    // a change drops ready until two source edges have passed
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        settle <= 2'h0;
        ok <= (ch == 0);
      end else if (clk_wr[ch]) begin
        settle <= 2'h0;
        ok <= 1'b0;
      end else if (clk_cfg[ch].source_sel == clock_ctrl_pkg::SRC_NONE
                   || clk_cfg[ch].clock_divide_sel == clock_ctrl_pkg::CLOCK_DIVIDE_SEL_NONE) begin
        ok <= 1'b0;
      end else if (settle == clock_ctrl_pkg::SETTLE_EDGES) begin
        ok <= 1'b1;
      end else if (src_rise) begin
        settle <= settle + 2'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions
  property p_lock_clear;
    @(posedge pclk) disable iff (!presetn) pll_wr |=> !lock;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock not cleared by write");

  property p_lock_rise;
    @(posedge pclk) disable iff (!presetn)
      $rose(lock) |-> $past(lock_cnt) == 6'h00 && $past(lock_busy);
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock set early");

  property p_irq_set;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == clock_ctrl_pkg::OFF_IRQ_ENABLE && pwdata[0] |=> irq_en[0];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("enable write lost");

  property p_irq_clr;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == clock_ctrl_pkg::OFF_IRQ_DISABLE && pwdata[0] |=> !irq_en[0];
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("disable write lost");

  property p_mask_read;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && paddr == clock_ctrl_pkg::OFF_IRQ_MASK |=> prdata[3] == !irq_en[3];
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

  property p_osc_rise;
    @(posedge pclk) disable iff (!presetn)
      $rose(osc_stable) |-> osc_ctrl[1] || $past(osc_cnt) == 11'h000;
  endproperty
  a_osc_rise: assert property (p_osc_rise) else $error("oscillator stable early");

  property p_meas_off;
    @(posedge pclk) disable iff (!presetn)
      (osc_ctrl[1:0] == 2'h0) [*2] |-> !measure_valid_flag;
  endproperty
  a_meas_off: assert property (p_meas_off) else $error("valid with oscillator off");

  property p_ref_zero;
    @(posedge pclk) disable iff (!presetn)
      (pll_cfg.in_divide == 8'h00) [*2] |-> !pll_ref_out;
  endproperty
  a_ref_zero: assert property (p_ref_zero) else $error("divider zero drives clock");

  property p_irq_out;
    @(posedge pclk) disable iff (!presetn)
      |(status_word & irq_en) |=> irq;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt not raised");
endmodule

// [verilog/clock_ctrl_pkg.sv]
// constants, field layouts and carrier types for the clock control block
package clock_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_OSC_CTRL = 8'h20;
  localparam logic [7:0] OFF_MAIN_FREQ_MEASURE = 8'h24;
  localparam logic [7:0] OFF_PLL_CONFIG = 8'h2C;
  localparam logic [7:0] OFF_MASTER_CLOCK_CONFIG = 8'h30;
  localparam logic [7:0] OFF_PROG_CLOCK0 = 8'h40;
  localparam logic [7:0] OFF_PROG_CLOCK1 = 8'h44;
  localparam logic [7:0] OFF_PROG_CLOCK2 = 8'h48;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h60;
  localparam logic [7:0] OFF_IRQ_DISABLE = 8'h64;
  localparam logic [7:0] OFF_CLOCK_STATUS = 8'h68;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h6C;
  // status / enable / mask bit positions
  localparam int BIT_OSC = 0;
  localparam int BIT_LOCK = 2;
  localparam int BIT_MCK = 3;
  localparam int BIT_PCK0 = 8;
  localparam logic [31:0] IRQ_BITS = 32'h0000_070D;
  // oscillator control field positions
  localparam int BIT_OSC_ON = 0;
  localparam int BIT_OSC_SKIP = 1;
  localparam int POS_OSC_TIME = 8;
  // measurement register layout
  localparam int BIT_MEAS_VALID = 16;
  // timing counts
  localparam logic [4:0] MEAS_SLOW_PERIODS = 5'h10;
  localparam int OSC_TIME_SHIFT = 3;
  localparam logic [1:0] SETTLE_EDGES = 2'h2;
  // reset values
  localparam logic [31:0] PLL_CONFIG_RESET = 32'h0000_3F10;
  localparam logic [4:0] CLK_CONFIG_RESET = 5'h00;
  // clock source, divider and usb divider codes, and channel count
  localparam logic [1:0] SRC_SLOW = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_NONE = 2'h2;
  localparam logic [1:0] SRC_PLL = 2'h3;
  localparam logic [2:0] CLOCK_DIVIDE_SEL_NONE = 3'h7;
  localparam logic [1:0] USB_DIV_NONE = 2'h3;
  localparam int NUM_CLK = 4;

  typedef struct packed {
    logic [1:0] zero_hi;
    logic [1:0] usb_clock_divide;
    logic zero_mid;
    logic [10:0] pll_factor;
    logic [1:0] freq_range;
    logic [5:0] pll_settle_cycles;
    logic [7:0] in_divide;
  } pll_cfg_t;

  typedef struct packed {
    logic [2:0] clock_divide_sel;
    logic [1:0] source_sel;
  } clk_cfg_t;
endpackage
